// [rtl/pmc_pkg.sv]
// constants and register map of the phase match check block
package pmc_pkg;
    localparam int MAG_W = 16;
    localparam int ANG_W = 16;
    localparam int FRQ_W = 32;
    localparam int TIM_W = 16;
    localparam int RATIO_FRAC = 12;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_MAG_LIM = 8'h04;
    localparam logic [7:0] OFS_FREQ_LIM = 8'h08;
    localparam logic [7:0] OFS_PHASE_LIM = 8'h0C;
    localparam logic [7:0] OFS_RATIO = 8'h10;
    localparam logic [7:0] OFS_ANGLE_CORR = 8'h14;
    localparam logic [7:0] OFS_CLOSE_TIME = 8'h18;
    localparam logic [7:0] OFS_LIVE_LIM = 8'h1C;
    localparam logic [7:0] OFS_DEAD_LIM = 8'h20;
    localparam logic [7:0] OFS_STATUS = 8'h24;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h28;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h2C;
    localparam logic [7:0] OFS_MAG_GAP = 8'h30;
    localparam logic [7:0] OFS_FREQ_GAP = 8'h34;
    localparam logic [7:0] OFS_PHASE_GAP = 8'h38;

    // control field positions
    localparam int CTRL_ENABLE = 0;
    localparam int CTRL_GEN_MODE = 1;
    localparam int CTRL_XFMR = 2;
    localparam int CTRL_LIVE_BUS_DEAD_LINE_EN = 3;
    localparam int CTRL_DEAD_BUS_LIVE_LINE_EN = 4;
    localparam int CTRL_DEAD_BUS_DEAD_LINE_EN = 5;
    localparam int CTRL_SUP_MAN = 6;
    localparam int CTRL_SUP_AUTO = 7;
    localparam int CTRL_REF_LO = 8;
    localparam int CTRL_W = 10;

    // status and interrupt bit positions
    localparam int ST_SYNC_OK = 0;
    localparam int ST_MAG_OK = 1;
    localparam int ST_FREQ_OK = 2;
    localparam int ST_PHASE_OK = 3;
    localparam int ST_OVERRIDE = 4;
    localparam int ST_BYPASS = 5;
    localparam int ST_RELEASE = 6;
    localparam int ST_W = 7;
    localparam int IRQ_SYNC_RISE = 0;
    localparam int IRQ_SYNC_FALL = 1;
    localparam int IRQ_RELEASE = 2;
    localparam int IRQ_REFUSED = 3;
    localparam int IRQ_W = 4;

    // reset values
    localparam logic [CTRL_W-1:0] RST_CTRL = 10'h0C1;
    localparam logic [MAG_W-1:0] RST_MAG_LIM = 16'h0100;
    localparam logic [FRQ_W-1:0] RST_FREQ_LIM = 32'h0000_3333;
    localparam logic [ANG_W-1:0] RST_PHASE_LIM = 16'h0E39;
    localparam logic [MAG_W-1:0] RST_RATIO = 16'h1000;
    localparam logic [ANG_W-1:0] RST_ANGLE_CORR = 16'h0000;
    localparam logic [TIM_W-1:0] RST_CLOSE_TIME = 16'h0000;
    localparam logic [MAG_W-1:0] RST_LIVE_LIM = 16'h0C00;
    localparam logic [MAG_W-1:0] RST_DEAD_LIM = 16'h0400;
endpackage

// [rtl/pmc_gap_calc.sv]
// magnitude, frequency and phase gap computation stage
`timescale 1ns/1ns
`default_nettype none
module pmc_gap_calc (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic gen_to_grid_mode,
    input wire logic xfmr_active,
    input wire logic [pmc_pkg::MAG_W-1:0] ratio,
    input wire logic [pmc_pkg::ANG_W-1:0] angle_corr,
    input wire logic [pmc_pkg::TIM_W-1:0] close_time,
    input wire logic [pmc_pkg::MAG_W-1:0] bus_mag,
    input wire logic [pmc_pkg::ANG_W-1:0] bus_ang,
    input wire logic [pmc_pkg::FRQ_W-1:0] bus_freq,
    input wire logic [pmc_pkg::MAG_W-1:0] line_mag,
    input wire logic [pmc_pkg::ANG_W-1:0] line_ang,
    input wire logic [pmc_pkg::FRQ_W-1:0] line_freq,
    output logic [pmc_pkg::MAG_W-1:0] magnitude_gap,
    output logic [pmc_pkg::FRQ_W-1:0] freq_gap,
    output logic [pmc_pkg::ANG_W-1:0] phase_gap
);
    logic [31:0] scaled_full;
    logic [pmc_pkg::MAG_W-1:0] bus_eff;
    logic signed [32:0] fdiff;
    logic signed [49:0] lead_full;
    logic [pmc_pkg::ANG_W-1:0] gap_raw;
    logic [pmc_pkg::ANG_W-1:0] gap_pred;
    logic [pmc_pkg::MAG_W-1:0] mag_nxt;
    logic [pmc_pkg::FRQ_W-1:0] freq_nxt;
    logic [pmc_pkg::ANG_W-1:0] phase_nxt;

    always_comb
    begin
        scaled_full = bus_mag * ratio;
        // bus magnitude scaled to line side, saturating
        if (!xfmr_active)
            bus_eff = bus_mag;
        else if (scaled_full[31:28] != 4'h0)
            bus_eff = 16'hFFFF;
        else
            bus_eff = scaled_full[27:12];
        mag_nxt = (bus_eff > line_mag) ? bus_eff - line_mag : line_mag - bus_eff;
        fdiff = $signed({1'b0, line_freq}) - $signed({1'b0, bus_freq});
        freq_nxt = fdiff[32] ? 32'(-fdiff) : fdiff[31:0];
        gap_raw = line_ang - bus_ang - (xfmr_active ? angle_corr : 16'h0000);
        // angle drift during breaker travel, modulo one turn
        lead_full = fdiff * $signed({1'b0, close_time});
        gap_pred = gen_to_grid_mode ? gap_raw + lead_full[31:16] : gap_raw;
        phase_nxt = gap_pred[pmc_pkg::ANG_W-1] ? 16'(-gap_pred) : gap_pred;
    end

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            magnitude_gap <= 16'hFFFF;
            freq_gap <= 32'hFFFF_FFFF;
            phase_gap <= 16'h8000;
        end
        else
        begin
            magnitude_gap <= mag_nxt;
            freq_gap <= freq_nxt;
            phase_gap <= phase_nxt;
        end
    end
endmodule
`default_nettype wire

// [rtl/pmc_top.sv]
// breaker closing release supervisor with register slave
//
// Chosen here: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ns
`default_nettype none
module pmc_top (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [pmc_pkg::MAG_W-1:0] bus_mag_1,
    input wire logic [pmc_pkg::MAG_W-1:0] bus_mag_2,
    input wire logic [pmc_pkg::MAG_W-1:0] bus_mag_3,
    input wire logic [pmc_pkg::ANG_W-1:0] bus_ang_1,
    input wire logic [pmc_pkg::ANG_W-1:0] bus_ang_2,
    input wire logic [pmc_pkg::ANG_W-1:0] bus_ang_3,
    input wire logic [pmc_pkg::FRQ_W-1:0] bus_freq,
    input wire logic [pmc_pkg::MAG_W-1:0] line_voltage_input,
    input wire logic [pmc_pkg::ANG_W-1:0] line_ang,
    input wire logic [pmc_pkg::FRQ_W-1:0] line_freq,
    input wire logic ext_bypass,
    input wire logic close_req_manual,
    input wire logic close_req_auto,
    output logic sync_ok,
    output logic close_release,
    output logic irq
);
    logic [pmc_pkg::CTRL_W-1:0] ctrl_r, ctrl_nxt;
    logic [pmc_pkg::MAG_W-1:0] mag_lim_r, mag_lim_nxt;
    logic [pmc_pkg::FRQ_W-1:0] freq_lim_r, freq_lim_nxt;
    logic [pmc_pkg::ANG_W-1:0] phase_lim_r, phase_lim_nxt;
    logic [pmc_pkg::MAG_W-1:0] ratio_r, ratio_nxt;
    logic [pmc_pkg::ANG_W-1:0] angle_corr_r, angle_corr_nxt;
    logic [pmc_pkg::TIM_W-1:0] close_time_r, close_time_nxt;
    logic [pmc_pkg::MAG_W-1:0] live_lim_r, live_lim_nxt;
    logic [pmc_pkg::MAG_W-1:0] dead_lim_r, dead_lim_nxt;
    logic [pmc_pkg::IRQ_W-1:0] irq_stat_r, irq_stat_nxt;
    logic [pmc_pkg::IRQ_W-1:0] irq_mask_r, irq_mask_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic wait_r, wait_nxt;
    logic sync_r, sync_nxt;
    logic rel_r, rel_nxt;
    logic irq_r, irq_nxt;
    logic [pmc_pkg::ST_W-1:0] status_r, status_nxt;

    logic [pmc_pkg::MAG_W-1:0] magnitude_gap;
    logic [pmc_pkg::FRQ_W-1:0] freq_gap;
    logic [pmc_pkg::ANG_W-1:0] phase_gap;
    logic [pmc_pkg::MAG_W-1:0] bus_mag_sel;
    logic [pmc_pkg::ANG_W-1:0] bus_ang_sel;
    logic mag_ok, freq_ok, phase_ok, match_ok;
    logic bus_live, bus_dead, line_live, line_dead;
    logic override_ok, permit, man_ok, auto_ok, any_req;
    logic acc_rd, acc_wr;
    logic [pmc_pkg::IRQ_W-1:0] irq_evt;

    // pick one of three bus channels
    function automatic logic [15:0] pick3(input logic [1:0] sel, input logic [15:0] a,
                                          input logic [15:0] b, input logic [15:0] c);
        case (sel)
            2'h1: pick3 = b;
            2'h2: pick3 = c;
            default: pick3 = a;
        endcase
    endfunction

    always_comb
    begin
        bus_mag_sel = pick3(ctrl_r[pmc_pkg::CTRL_REF_LO +: 2], bus_mag_1, bus_mag_2, bus_mag_3);
        bus_ang_sel = pick3(ctrl_r[pmc_pkg::CTRL_REF_LO +: 2], bus_ang_1, bus_ang_2, bus_ang_3);
    end

    pmc_gap_calc u_gap (
        .core_clk(core_clk),
        .reset(reset),
        .gen_to_grid_mode(ctrl_r[pmc_pkg::CTRL_GEN_MODE]),
        .xfmr_active(ctrl_r[pmc_pkg::CTRL_XFMR]),
        .ratio(ratio_r),
        .angle_corr(angle_corr_r),
        .close_time(close_time_r),
        .bus_mag(bus_mag_sel),
        .bus_ang(bus_ang_sel),
        .bus_freq(bus_freq),
        .line_mag(line_voltage_input),
        .line_ang(line_ang),
        .line_freq(line_freq),
        .magnitude_gap(magnitude_gap),
        .freq_gap(freq_gap),
        .phase_gap(phase_gap)
    );

    // closing decision
    always_comb
    begin
        mag_ok = magnitude_gap <= mag_lim_r;
        freq_ok = freq_gap <= freq_lim_r;
        phase_ok = phase_gap <= phase_lim_r;
        match_ok = ctrl_r[pmc_pkg::CTRL_ENABLE] && mag_ok && freq_ok && phase_ok;
        bus_live = bus_mag_sel >= live_lim_r;
        bus_dead = bus_mag_sel < dead_lim_r;
        line_live = line_voltage_input >= live_lim_r;
        line_dead = line_voltage_input < dead_lim_r;
        override_ok = (ctrl_r[pmc_pkg::CTRL_LIVE_BUS_DEAD_LINE_EN] && bus_live && line_dead)
                   || (ctrl_r[pmc_pkg::CTRL_DEAD_BUS_LIVE_LINE_EN] && bus_dead && line_live)
                   || (ctrl_r[pmc_pkg::CTRL_DEAD_BUS_DEAD_LINE_EN] && bus_dead && line_dead);
        permit = match_ok || override_ok || ext_bypass;
        man_ok = close_req_manual && (!ctrl_r[pmc_pkg::CTRL_SUP_MAN] || permit);
        auto_ok = close_req_auto && (!ctrl_r[pmc_pkg::CTRL_SUP_AUTO] || permit);
        any_req = close_req_manual || close_req_auto;
        sync_nxt = match_ok;
        rel_nxt = man_ok || auto_ok;
        status_nxt = {rel_nxt, ext_bypass, override_ok, phase_ok, freq_ok, mag_ok, match_ok};
    end

    // register slave
    always_comb
    begin
        acc_rd = avs_read && !wait_r;
        acc_wr = avs_write && !wait_r;
        wait_nxt = !((avs_read || avs_write) && wait_r);
        ctrl_nxt = ctrl_r;
        mag_lim_nxt = mag_lim_r;
        freq_lim_nxt = freq_lim_r;
        phase_lim_nxt = phase_lim_r;
        ratio_nxt = ratio_r;
        angle_corr_nxt = angle_corr_r;
        close_time_nxt = close_time_r;
        live_lim_nxt = live_lim_r;
        dead_lim_nxt = dead_lim_r;
        irq_mask_nxt = irq_mask_r;
        if (acc_wr)
        begin
            case (avs_address)
                pmc_pkg::OFS_CTRL: ctrl_nxt = avs_writedata[pmc_pkg::CTRL_W-1:0];
                pmc_pkg::OFS_MAG_LIM: mag_lim_nxt = avs_writedata[15:0];
                pmc_pkg::OFS_FREQ_LIM: freq_lim_nxt = avs_writedata;
                pmc_pkg::OFS_PHASE_LIM: phase_lim_nxt = avs_writedata[15:0];
                pmc_pkg::OFS_RATIO: ratio_nxt = avs_writedata[15:0];
                pmc_pkg::OFS_ANGLE_CORR: angle_corr_nxt = avs_writedata[15:0];
                pmc_pkg::OFS_CLOSE_TIME: close_time_nxt = avs_writedata[15:0];
                pmc_pkg::OFS_LIVE_LIM: live_lim_nxt = avs_writedata[15:0];
                pmc_pkg::OFS_DEAD_LIM: dead_lim_nxt = avs_writedata[15:0];
                pmc_pkg::OFS_IRQ_MASK: irq_mask_nxt = avs_writedata[pmc_pkg::IRQ_W-1:0];
                default: ;
            endcase
        end
        rdata_nxt = 32'h0000_0000;
        if (!wait_nxt && avs_read)
        begin
            case (avs_address)
                pmc_pkg::OFS_CTRL: rdata_nxt = 32'(ctrl_r);
                pmc_pkg::OFS_MAG_LIM: rdata_nxt = 32'(mag_lim_r);
                pmc_pkg::OFS_FREQ_LIM: rdata_nxt = freq_lim_r;
                pmc_pkg::OFS_PHASE_LIM: rdata_nxt = 32'(phase_lim_r);
                pmc_pkg::OFS_RATIO: rdata_nxt = 32'(ratio_r);
                pmc_pkg::OFS_ANGLE_CORR: rdata_nxt = 32'(angle_corr_r);
                pmc_pkg::OFS_CLOSE_TIME: rdata_nxt = 32'(close_time_r);
                pmc_pkg::OFS_LIVE_LIM: rdata_nxt = 32'(live_lim_r);
                pmc_pkg::OFS_DEAD_LIM: rdata_nxt = 32'(dead_lim_r);
                pmc_pkg::OFS_STATUS: rdata_nxt = 32'(status_r);
                pmc_pkg::OFS_IRQ_STAT: rdata_nxt = 32'(irq_stat_r);
                pmc_pkg::OFS_IRQ_MASK: rdata_nxt = 32'(irq_mask_r);
                pmc_pkg::OFS_MAG_GAP: rdata_nxt = 32'(magnitude_gap);
                pmc_pkg::OFS_FREQ_GAP: rdata_nxt = freq_gap;
                pmc_pkg::OFS_PHASE_GAP: rdata_nxt = 32'(phase_gap);
                default: rdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    // sticky events, cleared by reading; a new event wins over the clear
    // only the bits handed out in the read data are cleared, so a late event is kept
    always_comb
    begin
        irq_evt = '0;
        irq_evt[pmc_pkg::IRQ_SYNC_RISE] = sync_nxt && !sync_r;
        irq_evt[pmc_pkg::IRQ_SYNC_FALL] = !sync_nxt && sync_r;
        irq_evt[pmc_pkg::IRQ_RELEASE] = rel_nxt && !rel_r;
        irq_evt[pmc_pkg::IRQ_REFUSED] = any_req && !rel_nxt;
        irq_stat_nxt = irq_stat_r;
        if (acc_rd && avs_address == pmc_pkg::OFS_IRQ_STAT)
            irq_stat_nxt = irq_stat_r & ~rdata_r[pmc_pkg::IRQ_W-1:0];
        irq_stat_nxt = irq_stat_nxt | irq_evt;
        irq_nxt = |(irq_stat_nxt & irq_mask_nxt);
    end

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            ctrl_r <= pmc_pkg::RST_CTRL;
            mag_lim_r <= pmc_pkg::RST_MAG_LIM;
            freq_lim_r <= pmc_pkg::RST_FREQ_LIM;
            phase_lim_r <= pmc_pkg::RST_PHASE_LIM;
            ratio_r <= pmc_pkg::RST_RATIO;
            angle_corr_r <= pmc_pkg::RST_ANGLE_CORR;
            close_time_r <= pmc_pkg::RST_CLOSE_TIME;
            live_lim_r <= pmc_pkg::RST_LIVE_LIM;
            dead_lim_r <= pmc_pkg::RST_DEAD_LIM;
            irq_stat_r <= '0;
            irq_mask_r <= '0;
            rdata_r <= 32'h0000_0000;
            wait_r <= 1'b1;
            sync_r <= 1'b0;
            rel_r <= 1'b0;
            irq_r <= 1'b0;
            status_r <= '0;
        end
        else
        begin
            ctrl_r <= ctrl_nxt;
            mag_lim_r <= mag_lim_nxt;
            freq_lim_r <= freq_lim_nxt;
            phase_lim_r <= phase_lim_nxt;
            ratio_r <= ratio_nxt;
            angle_corr_r <= angle_corr_nxt;
            close_time_r <= close_time_nxt;
            live_lim_r <= live_lim_nxt;
            dead_lim_r <= dead_lim_nxt;
            irq_stat_r <= irq_stat_nxt;
            irq_mask_r <= irq_mask_nxt;
            rdata_r <= rdata_nxt;
            wait_r <= wait_nxt;
            sync_r <= sync_nxt;
            rel_r <= rel_nxt;
            irq_r <= irq_nxt;
            status_r <= status_nxt;
        end
    end

    assign avs_readdata = rdata_r;
    assign avs_waitrequest = wait_r;
    assign sync_ok = sync_r;
    assign close_release = rel_r;
    assign irq = irq_r;
endmodule
`default_nettype wire

// [sim/pmc_top_properties.sv]
// assertion checker for the phase match check top level
`timescale 1ns/1ns
`default_nettype none
module pmc_top_properties (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic [31:0] bus_freq,
    input wire logic [31:0] line_freq,
    input wire logic ext_bypass,
    input wire logic close_req_manual,
    input wire logic close_req_auto,
    input wire logic sync_ok,
    input wire logic close_release,
    input wire logic irq
);
    logic [31:0] fdiff;
    // slip only checked against the reset limit, which the bench keeps
    assign fdiff = (bus_freq > line_freq) ? bus_freq - line_freq : line_freq - bus_freq;
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    property p_wait_one; !avs_waitrequest |=> avs_waitrequest; endproperty
    a_wait_one: assert property (p_wait_one) else $error("wait low longer than one cycle");
    property p_wait_answer; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
    a_wait_answer: assert property (p_wait_answer) else $error("request not answered after one cycle");
    property p_no_spont; !(avs_read || avs_write) && avs_waitrequest |=> avs_waitrequest; endproperty
    a_no_spont: assert property (p_no_spont) else $error("answer without request");
    property p_rdata_zero; avs_waitrequest |-> avs_readdata == 32'h0; endproperty
    a_rdata_zero: assert property (p_rdata_zero) else $error("read data not zero while waiting");
    property p_release_needs_req; close_release |-> $past(close_req_manual || close_req_auto); endproperty
    a_release_needs_req: assert property (p_release_needs_req) else $error("release without request");
    property p_release_drop; !(close_req_manual || close_req_auto) |=> !close_release; endproperty
    a_release_drop: assert property (p_release_drop) else $error("release held after request drop");
    property p_bypass_release; (ext_bypass && close_req_manual) [*2] |-> close_release; endproperty
    a_bypass_release: assert property (p_bypass_release) else $error("bypass did not release");
    property p_sync_freq; sync_ok |-> $past(fdiff, 2) <= 32'h0000_3333; endproperty
    a_sync_freq: assert property (p_sync_freq) else $error("sync with slip over limit");
    c_sync: cover property ($rose(sync_ok));
    c_release: cover property ($rose(close_release));
    c_irq: cover property ($rose(irq));
endmodule
bind pmc_top pmc_top_properties u_pmc_top_properties (.core_clk, .reset, .avs_read, .avs_write, .avs_readdata,
    .avs_waitrequest, .bus_freq, .line_freq, .ext_bypass, .close_req_manual, .close_req_auto, .sync_ok,
    .close_release, .irq);
`default_nettype wire

// [sim/pmc_meas_model.sv]
// measurement front end model giving bus and line phasors per scene
`timescale 1ns/1ns
`default_nettype none
module pmc_meas_model (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [2:0] scene,
    output logic [15:0] bus_mag_r,
    output logic [15:0] bus_ang1_r,
    output logic [15:0] bus_ang3_r,
    output logic [31:0] bus_freq_r,
    output logic [15:0] line_mag_r,
    output logic [15:0] line_ang_r,
    output logic [31:0] line_freq_r
);
    localparam logic [31:0] F50 = 32'h0032_0000;
    logic [15:0] lm_nxt, la_nxt, ba_nxt;
    logic [31:0] lf_nxt;
    always_comb
    begin
        lm_nxt = 16'h2000;
        la_nxt = 16'h0000;
        ba_nxt = 16'h0000;
        lf_nxt = F50;
        case (scene)
            3'h1: lm_nxt = 16'h2101;
            3'h2: lf_nxt = F50 + 32'h0000_3334;
            3'h3: la_nxt = 16'h0E3A;
            3'h4:
            begin
                lm_nxt = 16'h1000;
                la_nxt = 16'h4000;
            end
            3'h5: lm_nxt = 16'h0000;
            3'h6:
            begin
                lf_nxt = F50 + 32'h0000_2000;
                la_nxt = 16'hF000;
            end
            3'h7: ba_nxt = 16'h8000;
            default: ;
        endcase
    end
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            line_mag_r <= 16'h0000;
            line_ang_r <= 16'h0000;
            bus_ang1_r <= 16'h0000;
            line_freq_r <= 32'h0;
        end
        else
        begin
            line_mag_r <= lm_nxt;
            line_ang_r <= la_nxt;
            bus_ang1_r <= ba_nxt;
            line_freq_r <= lf_nxt;
        end
    end
    assign bus_ang3_r = bus_ang1_r;
    assign bus_mag_r = 16'h2000;
    assign bus_freq_r = F50;
endmodule
`default_nettype wire

// [sim/tb_top.sv]
// self-checking bench for the phase match check block
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin errors++; $display("wrong value at %0t: got %h exp %h", $time, g, e); end end
module tb_top;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata, rd, bf, lf;
    logic avs_waitrequest, sync_ok, close_release, irq;
    logic [15:0] bm, ba1, ba3, lm, la;
    logic ext_bypass = 1'b0;
    logic close_req_manual = 1'b0;
    logic close_req_auto = 1'b0;
    logic [2:0] scene = 3'h0;
    int errors = 0;
    int n_checks = 0;
    logic [7:0] ofs [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h3C};
    logic [31:0] rst [6] = '{32'h0C1, 32'h0100, 32'h3333, 32'h0E39, 32'h1000, 32'h0};
    logic [2:0] sc [8] = '{3'h0, 3'h1, 3'h0, 3'h2, 3'h0, 3'h3, 3'h7, 3'h6};
    logic ex [8] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
    always #4 core_clk = ~core_clk;
    pmc_top u_pmc_top (.core_clk(core_clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .bus_mag_1(bm), .bus_mag_2(bm), .bus_mag_3(16'h0000), .bus_ang_1(ba1),
        .bus_ang_2(16'h0000), .bus_ang_3(ba3), .bus_freq(bf), .line_voltage_input(lm), .line_ang(la),
        .line_freq(lf), .ext_bypass(ext_bypass), .close_req_manual(close_req_manual),
        .close_req_auto(close_req_auto), .sync_ok(sync_ok), .close_release(close_release), .irq(irq));
    pmc_meas_model u_pmc_meas_model (.core_clk(core_clk), .reset(reset), .scene(scene), .bus_mag_r(bm),
        .bus_ang1_r(ba1), .bus_ang3_r(ba3), .bus_freq_r(bf), .line_mag_r(lm), .line_ang_r(la), .line_freq_r(lf));
    task automatic close_out();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        avs_address <= a;
        avs_read <= ~w;
        avs_write <= w;
        avs_writedata <= d;
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50)
        begin
            errors++;
            close_out();
        end
        else
        begin
            rd = avs_readdata;
            avs_read <= 1'b0;
            avs_write <= 1'b0;
            @(posedge core_clk);
        end
    endtask
    task automatic settle(input logic [2:0] s);
        scene <= s;
        repeat (4) @(posedge core_clk);
    endtask
    // angle offset as the configuring side derives it
    function automatic logic [15:0] corr_of(input int vg, input logic bus_side, input logic reversed);
        logic [15:0] c;
        c = 16'((vg * 65536) / 12);
        if (!bus_side)
            c = -c;
        if (reversed)
            c = -c;
        return c;
    endfunction
    initial
    begin
        repeat (20000) @(posedge core_clk);
        errors++;
        close_out();
    end
    initial
    begin
        repeat (6) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        for (int i = 0; i < 6; i++)
        begin
            xfer(ofs[i], 1'b0, 32'h0);
            `CHK(rd, rst[i])
        end
        for (int i = 0; i < 8; i++)
        begin
            settle(sc[i]);
            `CHK(sync_ok, ex[i])
        end
        xfer(pmc_pkg::OFS_FREQ_GAP, 1'b0, 32'h0);
        `CHK(rd, 32'h0000_2000)
        xfer(pmc_pkg::OFS_CTRL, 1'b1, 32'h1C1);
        settle(3'h7);
        `CHK(sync_ok, 1'b1)
        xfer(pmc_pkg::OFS_CTRL, 1'b1, 32'h0C3);
        xfer(pmc_pkg::OFS_CLOSE_TIME, 1'b1, 32'h8000);
        settle(3'h6);
        `CHK(sync_ok, 1'b1)
        xfer(pmc_pkg::OFS_CTRL, 1'b1, 32'h0C5);
        xfer(pmc_pkg::OFS_RATIO, 1'b1, 32'h0800);
        xfer(pmc_pkg::OFS_ANGLE_CORR, 1'b1, {16'h0, corr_of(3, 1'b1, 1'b0)});
        settle(3'h4);
        `CHK(sync_ok, 1'b1)
        xfer(pmc_pkg::OFS_ANGLE_CORR, 1'b1, {16'h0, corr_of(3, 1'b1, 1'b1)});
        settle(3'h4);
        `CHK(sync_ok, 1'b0)
        xfer(pmc_pkg::OFS_CTRL, 1'b1, 32'h0C1);
        settle(3'h3);
        close_req_manual <= 1'b1;
        repeat (3) @(posedge core_clk);
        `CHK(close_release, 1'b0)
        `CHK(irq, 1'b0)
        xfer(pmc_pkg::OFS_IRQ_MASK, 1'b1, 32'hF);
        `CHK(irq, 1'b1)
        xfer(pmc_pkg::OFS_IRQ_STAT, 1'b0, 32'h0);
        `CHK(rd[3], 1'b1)
        ext_bypass <= 1'b1;
        repeat (3) @(posedge core_clk);
        `CHK(close_release, 1'b1)
        ext_bypass <= 1'b0;
        settle(3'h5);
        `CHK(close_release, 1'b0)
        xfer(pmc_pkg::OFS_CTRL, 1'b1, 32'h0C9);
        repeat (3) @(posedge core_clk);
        `CHK(close_release, 1'b1)
        xfer(pmc_pkg::OFS_CTRL, 1'b1, 32'h081);
        settle(3'h3);
        `CHK(close_release, 1'b1)
        // channel three is a dead bus; matching off so only overrides permit
        xfer(pmc_pkg::OFS_CTRL, 1'b1, 32'h2D0);
        settle(3'h0);
        `CHK(close_release, 1'b1)
        settle(3'h5);
        `CHK(close_release, 1'b0)
        xfer(pmc_pkg::OFS_CTRL, 1'b1, 32'h2F0);
        repeat (3) @(posedge core_clk);
        `CHK(close_release, 1'b1)
        xfer(pmc_pkg::OFS_CTRL, 1'b1, 32'h081);
        settle(3'h3);
        close_req_manual <= 1'b0;
        close_req_auto <= 1'b1;
        repeat (3) @(posedge core_clk);
        `CHK(close_release, 1'b0)
        close_req_auto <= 1'b0;
        repeat (3) @(posedge core_clk);
        xfer(pmc_pkg::OFS_IRQ_STAT, 1'b0, 32'h0);
        xfer(pmc_pkg::OFS_IRQ_STAT, 1'b0, 32'h0);
        `CHK(rd, 32'h0)
        repeat (2) @(posedge core_clk);
        `CHK(irq, 1'b0)
        close_out();
    end
endmodule
`default_nettype wire
